// ===== rtl/keypad_host_params.svh
`ifndef KEYPAD_HOST_PARAMS_SVH
`define KEYPAD_HOST_PARAMS_SVH

`define DEV_ADDR           7'h51
`define CMD_FIFO_READ      8'h20
`define CMD_FIFO_REREAD    8'h21
`define CMD_DEBOUNCE       8'h22
`define CMD_INT_CODE       8'hD0
`define CMD_EXT_IRQ_CFG    8'hD1
`define CMD_STAT_CODE      8'hE0
`define CMD_ACTIVE         8'hE4
`define CMD_READ_ERR       8'hF0
`define STAT_RESET         8'h00
`define STAT_WAKE          8'h02
`define STAT_ACK           8'h06
`define STAT_NOACK         8'h15
`define EMPTY_CODE         8'h00
`define INT_ERR_BIT        3
`define INT_EX1_BIT        2
`define INT_EX0_BIT        1
`define INT_KEY_BIT        0
`define ERR_QOVF_BIT       6
`define ERR_LOST_BIT       4
`define ERR_KEYS_BIT       2
`define ERR_CMD_BIT        1
`define ERR_EARLY_BIT      0
`define EVENT_WIDTH        8
`define EVENT_DEPTH        14
`define DEBOUNCE_RST       8'h03
`define ACTIVE_RST         8'h7D
`define STEP_MS            4
`define CLK_MHZ            125
`define STEP_CYCLES        (`STEP_MS * 1000 * `CLK_MHZ)
`define STEP_CNT_W         20
`define STRETCH_CYCLES     4'h4
`define BYTE_BITS          4'h8

`endif

// ===== rtl/keypad_host_pkg.sv
package keypad_host_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RX     = 3'b001,
        ST_ACK_RX = 3'b010,
        ST_TX     = 3'b011,
        ST_ACK_TX = 3'b100
    } link_state_e;
endpackage : keypad_host_pkg

// ===== rtl/keypad_host_command_interface.sv
`timescale 1ns/10ps
`include "keypad_host_params.svh"

module key_event_fifo #(
    parameter int WIDTH = `EVENT_WIDTH,
    parameter int DEPTH = `EVENT_DEPTH
) (
    // Clock and reset
    input  wire logic                         i_core_clk,
    input  wire logic                         i_sys_rst,
    // Fill side
    input  wire logic                         i_valid,
    output logic                              o_ready,
    input  wire logic [WIDTH-1:0]             i_data,
    // Drain side
    output logic                              o_valid,
    input  wire logic                         i_ready,
    output logic      [WIDTH-1:0]             o_data,
    // Non-destructive look-ahead
    input  wire logic [$clog2(DEPTH)-1:0]     i_peek_idx,
    output logic      [WIDTH-1:0]             o_peek_data,
    output logic      [$clog2(DEPTH):0]       o_count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] ptr_add(input logic [AW-1:0] p, input logic [AW-1:0] n);
        logic [AW:0] s;
        s = {1'b0, p} + {1'b0, n};
        return (s >= (AW+1)'(DEPTH)) ? AW'(s - (AW+1)'(DEPTH)) : s[AW-1:0];
    endfunction : ptr_add

    assign o_ready     = (cnt_ff != (AW+1)'(DEPTH));
    assign o_valid     = (cnt_ff != '0);
    assign push        = i_valid & o_ready;
    assign pop         = o_valid & i_ready;
    assign o_data      = mem[rd_ptr_ff];
    assign o_peek_data = mem[ptr_add(rd_ptr_ff, i_peek_idx)];
    assign o_count     = cnt_ff;

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= i_data;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
        end else begin
            if (push) wr_ptr_ff <= ptr_add(wr_ptr_ff, AW'(1));
            if (pop) rd_ptr_ff <= ptr_add(rd_ptr_ff, AW'(1));
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : key_event_fifo

// Operation
// - Address byte: seven address bits, direction bit
// - Write: address, command, data bytes
// - Read: address, command, address read, data
// - Bus activity wakes; first address unacknowledged
// - Host retries; awake device acknowledges address
// - Start byte wakes, never acknowledged
// - Device may stretch clock low
// - Interrupt read returns, clears, releases request
// - Interrupt code: error, pin edges, key
// - Single enabled pin sets both edge bits
// - Enabled pin edge wakes, asserts request
// - Error read returns and clears code
// - Error code bit layout, unused bits zero
// - Status codes reset, wake, ack, noack
// - Fourteen events; empty reads return zero
// - Reread returns events without popping
// - New key press asserts request until read
// - Debounce default, programmable by command
// - Active time before halt, programmable
// - Address byte A2 write, A3 read
// - Event byte top bit marks press
module keypad_host_command_interface #(
    parameter int unsigned STEP_CYCLES = `STEP_CYCLES
) (
    // Clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_sys_rst,
    // Two-wire bus, open drain
    input  wire logic                   i_scl,
    input  wire logic                   i_sda,
    output logic                        o_sda_out,
    output logic                        o_sda_oe,
    output logic                        o_scl_out,
    output logic                        o_scl_oe,
    // Key events from the scanner
    input  wire logic                   i_key_valid,
    input  wire logic                   i_key_pressed,
    input  wire logic [6:0]             i_key_code,
    output logic                        o_key_ready,
    // Scanner reports
    input  wire logic                   i_keys_down,
    input  wire logic                   i_too_many_keys,
    input  wire logic                   i_irq_lost,
    // Interrupt-capable pins
    input  wire logic                   i_gpio_pin0,
    input  wire logic                   i_gpio_pin1,
    // Host-facing status
    output logic                        o_irq_n,
    output logic                        o_halt,
    output keypad_host_pkg::byte_t      o_debounce_steps,
    output keypad_host_pkg::byte_t      o_active_steps
);
    import keypad_host_pkg::*;

    logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    logic [1:0] gp_s1, gp_s2, gp_d;
    link_state_e st_ff;
    logic [3:0] bit_cnt_ff, stretch_ff, reread_ff;
    logic [1:0] byte_idx_ff, ext_en_ff;
    byte_t shift_ff, cmd_ff, status_ff, err_ff, debounce_ff, active_ff, active_cnt_ff;
    logic [3:0] int_ff;
    logic sda_oe_ff, rd_mode_ff, halt_ff, wake_pend_ff, irq_ff;
    logic [`STEP_CNT_W-1:0] step_cnt_ff;

    assign o_sda_out        = 1'b0;
    assign o_scl_out        = 1'b0;
    assign o_sda_oe         = sda_oe_ff;
    assign o_scl_oe         = (stretch_ff != 4'h0);
    assign o_irq_n          = ~irq_ff;
    assign o_halt           = halt_ff;
    assign o_debounce_steps = debounce_ff;
    assign o_active_steps   = active_ff;

    // Bus edges and conditions, seen only after two flops
    wire scl_rise  = scl_s2 & ~scl_d;
    wire scl_fall  = ~scl_s2 & scl_d;
    wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
    wire stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
    wire byte_done = (st_ff == ST_RX) & scl_fall & (bit_cnt_ff == `BYTE_BITS);
    wire addr_hit  = (shift_ff[7:1] == `DEV_ADDR);
    wire addr_ack  = addr_hit & ~wake_pend_ff;
    wire is_addr   = (byte_idx_ff == 2'd0);
    wire is_cmd    = (byte_idx_ff == 2'd1);
    wire cmd_valid = (shift_ff == `CMD_FIFO_READ) | (shift_ff == `CMD_FIFO_REREAD) |
                     (shift_ff == `CMD_DEBOUNCE) | (shift_ff == `CMD_INT_CODE) |
                     (shift_ff == `CMD_EXT_IRQ_CFG) | (shift_ff == `CMD_STAT_CODE) |
                     (shift_ff == `CMD_ACTIVE) | (shift_ff == `CMD_READ_ERR);
    wire stat_cmd  = (shift_ff == `CMD_STAT_CODE);
    wire cmd_taken = byte_done & is_cmd;
    wire data_wr   = byte_done & (byte_idx_ff == 2'd2);
    wire load_tx   = scl_fall & (((st_ff == ST_ACK_RX) & rd_mode_ff) | (st_ff == ST_ACK_TX));

    // Key event path; press marked in the top bit
    logic             fifo_ready, fifo_valid;
    byte_t            fifo_head, fifo_peek;
    logic [4:0]       fifo_count;
    wire  byte_t      key_byte  = {i_key_pressed, i_key_code};
    wire              key_push  = i_key_valid & fifo_ready;
    wire              fifo_pop  = load_tx & (cmd_ff == `CMD_FIFO_READ) & fifo_valid;
    assign o_key_ready = fifo_ready;

    key_event_fifo #(.WIDTH(`EVENT_WIDTH), .DEPTH(`EVENT_DEPTH)) u_key_event_fifo (
        .i_core_clk  (i_core_clk),
        .i_sys_rst   (i_sys_rst),
        .i_valid     (i_key_valid),
        .o_ready     (fifo_ready),
        .i_data      (key_byte),
        .o_valid     (fifo_valid),
        .i_ready     (fifo_pop),
        .o_data      (fifo_head),
        .i_peek_idx  (reread_ff),
        .o_peek_data (fifo_peek),
        .o_count     (fifo_count)
    );

    // External pin edges; mapping of edge bits
    wire [1:0] pin_edge = (gp_s2 ^ gp_d) & ext_en_ff;
    wire [1:0] ext_set  = (&ext_en_ff) ? pin_edge : {2{|pin_edge}};

    // error sources in their bit positions
    byte_t err_set;
    always_comb begin
        err_set                 = 8'h00;
        err_set[`ERR_QOVF_BIT]  = i_key_valid & ~fifo_ready;
        err_set[`ERR_LOST_BIT]  = i_irq_lost;
        err_set[`ERR_KEYS_BIT]  = i_too_many_keys;
        err_set[`ERR_CMD_BIT]   = cmd_taken & ~cmd_valid;
        err_set[`ERR_EARLY_BIT] = byte_done & is_addr & addr_hit & wake_pend_ff;
    end

    wire [3:0] int_set = {|err_set, ext_set, key_push};
    // interrupt read clears; error read clears
    wire int_clr = load_tx & (cmd_ff == `CMD_INT_CODE);
    wire err_clr = load_tx & (cmd_ff == `CMD_READ_ERR);
    wire irq_raise = (key_push & i_key_pressed) | (|ext_set) | (|err_set);

    // empty code past stored events; reread by offset
    byte_t tx_byte;
    always_comb begin
        if (cmd_ff == `CMD_INT_CODE) tx_byte = {4'h0, int_ff};
        else if (cmd_ff == `CMD_STAT_CODE) tx_byte = status_ff;
        else if (cmd_ff == `CMD_READ_ERR) tx_byte = err_ff;
        else if (cmd_ff == `CMD_FIFO_READ) tx_byte = fifo_valid ? fifo_head : `EMPTY_CODE;
        else if (cmd_ff == `CMD_FIFO_REREAD) tx_byte = ({1'b0, reread_ff} < fifo_count) ? fifo_peek : `EMPTY_CODE;
        else tx_byte = `EMPTY_CODE;
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
            {gp_s1, gp_s2, gp_d} <= 6'h00;
        end else begin
            {scl_s1, scl_s2, scl_d} <= {i_scl, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_d} <= {i_sda, sda_s1, sda_s2};
            {gp_s1, gp_s2, gp_d} <= {{i_gpio_pin1, i_gpio_pin0}, gp_s1, gp_s2};
        end
    end

    // Byte-level link engine
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_ff       <= ST_IDLE;
            bit_cnt_ff  <= 4'h0;
            byte_idx_ff <= 2'd0;
            shift_ff    <= 8'h00;
            sda_oe_ff   <= 1'b0;
            rd_mode_ff  <= 1'b0;
            stretch_ff  <= 4'h0;
        end else if (start_det) begin
            // repeated start restarts at the address byte
            st_ff       <= ST_RX;
            bit_cnt_ff  <= 4'h0;
            byte_idx_ff <= 2'd0;
            sda_oe_ff   <= 1'b0;
            stretch_ff  <= 4'h0;
        end else if (stop_det) begin
            st_ff     <= ST_IDLE;
            sda_oe_ff <= 1'b0;
        end else begin
            if (stretch_ff != 4'h0) stretch_ff <= stretch_ff - 4'h1;
            case (st_ff)
                ST_RX: begin
                    if (scl_rise) begin
                        shift_ff   <= {shift_ff[6:0], sda_s2};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        // start byte never matches, so no acknowledge
                        sda_oe_ff  <= is_addr ? addr_ack : 1'b1;
                        rd_mode_ff <= is_addr & addr_ack & shift_ff[0];
                        st_ff      <= ST_ACK_RX;
                    end
                end
                ST_ACK_RX: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        if (!sda_oe_ff) begin
                            st_ff     <= ST_IDLE;
                        end else if (rd_mode_ff) begin
                            // data byte follows read address; hold clock while loading
                            shift_ff   <= tx_byte;
                            sda_oe_ff  <= ~tx_byte[7];
                            stretch_ff <= `STRETCH_CYCLES;
                            st_ff      <= ST_TX;
                        end else begin
                            sda_oe_ff <= 1'b0;
                            if (byte_idx_ff != 2'd2) byte_idx_ff <= byte_idx_ff + 2'd1;
                            st_ff <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall && stretch_ff == 4'h0) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        if (bit_cnt_ff == `BYTE_BITS - 4'h1) begin
                            sda_oe_ff <= 1'b0;
                            st_ff     <= ST_ACK_TX;
                        end else begin
                            shift_ff  <= {shift_ff[6:0], 1'b0};
                            sda_oe_ff <= ~shift_ff[6];
                        end
                    end
                end
                ST_ACK_TX: begin
                    // host negative acknowledge ends the read
                    if (scl_rise && sda_s2) begin
                        st_ff <= ST_IDLE;
                    end else if (scl_fall) begin
                        bit_cnt_ff <= 4'h0;
                        shift_ff   <= tx_byte;
                        sda_oe_ff  <= ~tx_byte[7];
                        stretch_ff <= `STRETCH_CYCLES;
                        st_ff      <= ST_TX;
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // Command effects and host-visible codes; a new event wins over a clear
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_ff      <= 8'h00;
            status_ff   <= `STAT_RESET;
            err_ff      <= 8'h00;
            int_ff      <= 4'h0;
            irq_ff      <= 1'b0;
            ext_en_ff   <= 2'b00;
            debounce_ff <= `DEBOUNCE_RST;
            active_ff   <= `ACTIVE_RST;
            reread_ff   <= 4'h0;
        end else begin
            if (cmd_taken) begin
                cmd_ff    <= shift_ff;
                reread_ff <= 4'h0;
            end
            // last command outcome; a status read must not hide it
            if (cmd_taken && !stat_cmd) begin
                status_ff <= cmd_valid ? `STAT_ACK : `STAT_NOACK;
            end else if (halt_ff && (|pin_edge)) begin
                status_ff <= `STAT_WAKE;
            end
            if (data_wr) begin
                if (cmd_ff == `CMD_EXT_IRQ_CFG) ext_en_ff <= shift_ff[1:0];
                if (cmd_ff == `CMD_DEBOUNCE) debounce_ff <= shift_ff;
                if (cmd_ff == `CMD_ACTIVE) active_ff <= shift_ff;
            end
            if (load_tx && cmd_ff == `CMD_FIFO_REREAD) reread_ff <= reread_ff + 4'h1;
            err_ff <= (err_clr ? 8'h00 : err_ff) | err_set;
            int_ff <= (int_clr ? 4'h0 : int_ff) | int_set;
            irq_ff <= (irq_ff & ~int_clr) | irq_raise;
        end
    end

    wire busy      = i_keys_down | (st_ff != ST_IDLE);
    wire step_tick = (step_cnt_ff == `STEP_CNT_W'(STEP_CYCLES - 1));
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            step_cnt_ff   <= '0;
            active_cnt_ff <= 8'h00;
            halt_ff       <= 1'b0;
            wake_pend_ff  <= 1'b0;
        end else begin
            step_cnt_ff <= (step_tick || busy) ? '0 : step_cnt_ff + `STEP_CNT_W'(1);
            if (start_det || (|pin_edge) || busy) begin
                halt_ff       <= 1'b0;
                active_cnt_ff <= 8'h00;
            end else if (step_tick && !halt_ff) begin
                active_cnt_ff <= active_cnt_ff + 8'h01;
                if (active_cnt_ff + 8'h01 >= active_ff) halt_ff <= 1'b1;
            end
            if (start_det && halt_ff) wake_pend_ff <= 1'b1;
            else if (byte_done && is_addr) wake_pend_ff <= 1'b0;
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    property p_wake_nack;
        byte_done && is_addr && wake_pend_ff |=> !o_sda_oe;
    endproperty
    a_wake_nack: assert property (p_wake_nack) else $error("address acked right after wake");
    property p_addr_ack;
        byte_done && is_addr && addr_hit && !wake_pend_ff |=> o_sda_oe && st_ff == ST_ACK_RX;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
    property p_int_read;
        int_clr && int_set == 4'h0 && !irq_raise |=> int_ff == 4'h0 && o_irq_n;
    endproperty
    a_int_read: assert property (p_int_read) else $error("interrupt read did not clear");
    property p_single_pin;
        ext_en_ff == 2'b01 && pin_edge[0] |=> int_ff[2:1] == 2'b11 && !o_irq_n;
    endproperty
    a_single_pin: assert property (p_single_pin) else $error("single pin edge bits wrong");
    property p_err_read;
        err_clr && err_set == 8'h00 |=> err_ff == 8'h00;
    endproperty
    a_err_read: assert property (p_err_read) else $error("error read did not clear");
    property p_status;
        cmd_taken && stat_cmd |=> $stable(status_ff);
    endproperty
    a_status: assert property (p_status) else $error("status read changed status code");
    property p_full;
        !o_key_ready |-> fifo_count == 5'(`EVENT_DEPTH);
    endproperty
    a_full: assert property (p_full) else $error("queue refused before full");
    property p_reread;
        load_tx && cmd_ff == `CMD_FIFO_REREAD && !key_push |=> fifo_count == $past(fifo_count);
    endproperty
    a_reread: assert property (p_reread) else $error("reread moved the queue");
    property p_press_irq;
        key_push && i_key_pressed |=> !o_irq_n ##1 (!o_irq_n || $past(int_clr));
    endproperty
    a_press_irq: assert property (p_press_irq) else $error("press did not raise request");
    property p_err_flag;
        |err_set |=> int_ff[`INT_ERR_BIT] && !o_irq_n;
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("error did not raise flag");
    c_read: cover property (load_tx && cmd_ff == `CMD_INT_CODE);
    c_wake: cover property (byte_done && is_addr && wake_pend_ff);
    c_full: cover property (!o_key_ready);
endmodule : keypad_host_command_interface

// ===== verification/bus_host_model.sv
`timescale 1ns/10ps
module bus_host_model (
    // Pin levels
    input  wire logic i_scl_pin,
    input  wire logic i_sda_pin,
    // Host pull-downs
    output logic      o_scl_low,
    output logic      o_sda_low
);
    initial begin
        o_scl_low = 1'b0;
        o_sda_low = 1'b0;
    end
    task automatic start();
        o_sda_low = 1'b0;
        #31.25 o_scl_low = 1'b0;
        #31.25 o_sda_low = 1'b1;
        #31.25 o_scl_low = 1'b1;
        #31.25;
    endtask : start
    task automatic stop();
        o_sda_low = 1'b1;
        #31.25 o_scl_low = 1'b0;
        #31.25 o_sda_low = 1'b0;
        #31.25;
    endtask : stop
    task automatic bit_io(input logic b, output logic s);
        int n;
        o_sda_low = !b;
        #31.25 o_scl_low = 1'b0;
        for (n = 0; n < 100 && !i_scl_pin; n++) #1;
        #31.25 s = i_sda_pin;
        #31.25 o_scl_low = 1'b1;
        #31.25;
    endtask : bit_io
    // MSB first, host nacks last read byte
    task automatic xfer(input logic [7:0] tx, input logic a_in, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(a_in, s);
        ack = !s;
    endtask : xfer
endmodule : bus_host_model

// ===== verification/test_keypad_host_command_interface.sv
`timescale 1ns/10ps
module test_keypad_host_command_interface;
    import keypad_host_pkg::*;
    logic  clk = 0, rst = 1, kv = 0, kp = 0, tmk = 0, lost = 0, p0 = 0, p1 = 0, kd = 0;
    logic  [6:0] kc = 0;
    logic  hs, hd, sda_oe, scl_oe, krdy, irq_n, halt, ack, sdo, sco;
    byte_t deb, act, r, rb[16], ev[16];
    int    miscompares, checks_done, cyc, n, i, k;
    wire   scl = !(hs | scl_oe);
    wire   sda = !(hd | sda_oe);
    keypad_host_command_interface #(.STEP_CYCLES(20)) u_keypad_host_command_interface (
        .i_core_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo), .o_sda_oe(sda_oe),
        .o_scl_out(sco), .o_scl_oe(scl_oe), .i_key_valid(kv), .i_key_pressed(kp), .i_key_code(kc),
        .o_key_ready(krdy), .i_keys_down(kd), .i_too_many_keys(tmk), .i_irq_lost(lost),
        .i_gpio_pin0(p0), .i_gpio_pin1(p1), .o_irq_n(irq_n), .o_halt(halt),
        .o_debounce_steps(deb), .o_active_steps(act));
    bus_host_model u_bus_host_model (.i_scl_pin(scl), .i_sda_pin(sda), .o_scl_low(hs), .o_sda_low(hd));
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(byte_t c, byte_t d, bit has);
        byte_t x;
        u_bus_host_model.start();
        u_bus_host_model.xfer(8'hA2, 1'b1, x, ack);
        chk("write address ack", ack, 1);
        u_bus_host_model.xfer(c, 1'b1, x, ack);
        if (has) u_bus_host_model.xfer(d, 1'b1, x, ack);
        u_bus_host_model.stop();
    endtask : wr
    task automatic rd(byte_t c, int m);
        u_bus_host_model.start();
        u_bus_host_model.xfer(8'hA2, 1'b1, r, ack);
        u_bus_host_model.xfer(c, 1'b1, r, ack);
        u_bus_host_model.start();
        u_bus_host_model.xfer(8'hA3, 1'b1, r, ack);
        chk("read address ack", ack, 1);
        for (int j = 0; j < m; j++) u_bus_host_model.xfer(8'hFF, j == m - 1, rb[j], ack);
        u_bus_host_model.stop();
    endtask : rd
    task automatic push(byte_t e);
        @(posedge clk);
        #1 kv = 1;
        {kp, kc} = e;
        // Ready is looked at where it is settled, then the next edge takes the event
        while (krdy !== 1'b1) @(negedge clk);
        @(posedge clk);
        #1 kv = 0;
    endtask : push
    task automatic tog(bit sel);
        @(posedge clk);
        #1 if (sel) p1 = ~p1;
        else p0 = ~p0;
        repeat (10) @(posedge clk);
    endtask : tog
    task automatic to_halt();
        for (n = 0; n < 3000 && halt !== 1'b1; n++) @(posedge clk);
        chk("halt", halt, 1);
    endtask : to_halt
    initial begin
        void'($urandom(49));
        repeat (16) @(posedge clk);
        #1 rst = 0;
        repeat (4) @(posedge clk);
        chk("irq_n", irq_n, 1);
        chk("sda out", sdo, 0);
        chk("scl out", sco, 0);
        chk("debounce", deb, 8'h03);
        chk("active", act, 8'h7D);
        rd(8'hE0, 1);
        chk("status", rb[0], 8'h00);
        k = 3 + $urandom % 4;
        for (i = 0; i < k; i++) ev[i] = {i == 0 ? 1'b1 : 1'($urandom), 7'(1 + $urandom % 127)};
        for (i = 0; i < k; i++) push(ev[i]);
        repeat (2) @(posedge clk);
        chk("irq_n", irq_n, 0);
        rd(8'h21, k + 1);
        for (i = 0; i <= k; i++) chk("reread", rb[i], i < k ? ev[i] : 8'h00);
        rd(8'h20, k + 1);
        for (i = 0; i <= k; i++) chk("fifo", rb[i], i < k ? ev[i] : 8'h00);
        rd(8'hD0, 2);
        chk("int", rb[0], 8'h01);
        chk("int cleared", rb[1], 8'h00);
        chk("irq_n", irq_n, 1);
        rd(8'hE0, 1);
        chk("status", rb[0], 8'h06);
        wr(8'h55, 0, 0);
        rd(8'hE0, 1);
        chk("status", rb[0], 8'h15);
        rd(8'hD0, 1);
        chk("int", rb[0], 8'h08);
        rd(8'hF0, 2);
        chk("err", rb[0], 8'h02);
        chk("err cleared", rb[1], 8'h00);
        r = 8'(1 + $urandom % 255);
        wr(8'h22, r, 1);
        chk("debounce", deb, r);
        @(posedge clk);
        #1 {tmk, lost} = 2'b11;
        @(posedge clk);
        #1 {tmk, lost} = 2'b00;
        rd(8'hD0, 1);
        chk("int", rb[0], 8'h08);
        rd(8'hF0, 1);
        chk("err", rb[0], 8'h14);
        for (i = 0; i < 14; i++) push({1'b1, 7'(1 + $urandom % 127)});
        @(posedge clk);
        #1 kv = 1;
        @(posedge clk);
        chk("ready full", krdy, 0);
        #1 kv = 0;
        rd(8'hD0, 1);
        chk("int", rb[0], 8'h09);
        rd(8'hF0, 1);
        chk("err", rb[0], 8'h40);
        rd(8'h20, 15);
        chk("fifo end", rb[14], 8'h00);
        for (k = 0; k < 4; k++) begin
            wr(8'hD1, k < 2 ? 8'(k + 1) : 8'h03, 1);
            tog(k[0]);
            rd(8'hD0, 1);
            chk("edge int", rb[0], k < 2 ? 8'h06 : 8'(2 << k[0]));
        end
        wr(8'hE4, 8'h02, 1);
        chk("active", act, 8'h02);
        @(posedge clk);
        #1 kd = 1;
        repeat (100) @(posedge clk);
        chk("halt with keys down", halt, 0);
        #1 kd = 0;
        to_halt();
        tog(0);
        chk("wake", halt, 0);
        chk("irq_n", irq_n, 0);
        rd(8'hE0, 1);
        chk("wake status", rb[0], 8'h02);
        to_halt();
        u_bus_host_model.start();
        u_bus_host_model.xfer(8'hA2, 1'b1, r, ack);
        chk("first address ack", ack, 0);
        u_bus_host_model.stop();
        rd(8'hD0, 1);
        chk("int", rb[0], 8'h0A);
        rd(8'hF0, 1);
        chk("err", rb[0], 8'h01);
        to_halt();
        u_bus_host_model.start();
        u_bus_host_model.xfer(8'h01, 1'b1, r, ack);
        chk("start byte ack", ack, 0);
        u_bus_host_model.stop();
        repeat (10) @(posedge clk);
        chk("wake", halt, 0);
        summarize();
    end
endmodule : test_keypad_host_command_interface
